/* pkg/result_bank_regs.vh */
// Command codes, reset values, field positions and widths of the result register bank.
`ifndef RESULT_BANK_REGS_VH
`define RESULT_BANK_REGS_VH

// Command word layout: the top bit selects a read, the low byte picks the register.
`define CMD_READ_BIT        15
`define CMD_INDEX_MSB       7

// Read command codes of the analog results, listed in their fixed order.
`define RD_HORIZ_POSITION   16'h8000
`define RD_VERT_POSITION    16'h8001
`define RD_PRESSURE_FIRST   16'h8002
`define RD_PRESSURE_SECOND  16'h8003
`define RD_BATTERY_ONE      16'h8005
`define RD_BATTERY_TWO      16'h8006
`define RD_AUXILIARY_ONE    16'h8007
`define RD_AUXILIARY_TWO    16'h8008
`define RD_THERMAL_ONE      16'h8009
`define RD_THERMAL_TWO      16'h800a

// Read command codes of the keypad results.
`define RD_KEY_SCAN_RAW     16'h8004
`define RD_KEY_PENDING      16'h8010
`define RD_KEY_STATUS       16'h8011

// Writable registers kept in this bank, with their write and read codes.
`define WR_DAC_DATA         16'h000b
`define RD_DAC_DATA         16'h800b
`define WR_WEAK_RES_OFF     16'h004e
`define RD_WEAK_RES_OFF     16'h804e

// Reset values.
`define RESULT_RESET        16'h0000
`define DAC_DATA_RESET      16'h1000
`define WEAK_RES_OFF_RESET  16'h0000

// Field positions and widths.
`define ANALOG_RESULT_MSB   11
`define ANALOG_SLOT_COUNT   11
`define ANALOG_SLOT_KEYPAD  4'h4
`define WEAK_RES_OFF_MSB    15
`define WEAK_RES_OFF_LSB    8
`define COLUMN_MASK_MSB     15
`define COLUMN_MASK_LSB     12
`define KEY_COUNT           16
`define KEYS_PER_COLUMN     4

`endif

/* logic/column_block_expand.v */
// Spreads the four column block bits over the sixteen key positions of the matrix.
`include "result_bank_regs.vh"

module column_block_expand (
    // Column block bits, column 1 in bit 0.
    input  wire [3:0]  column_block,
    // One block flag per key.
    output wire [15:0] key_block
);

    // Key index is 4*(column-1)+(row-1), so the column block bit is the index divided by four.
    genvar k;
    generate
        for (k = 0; k < `KEY_COUNT; k = k + 1) begin : g_key
            assign key_block[k] = column_block[k / `KEYS_PER_COLUMN];
        end
    endgenerate

endmodule

/* logic/analog_result_file.v */
// Flip-flop store of the analog conversion results, indexed by the low nibble of the read code.
`include "result_bank_regs.vh"

module analog_result_file (
    // Clock and reset.
    input  wire        clk_sys,
    input  wire        rst_n,
    // Load port from the converter.
    input  wire        load,
    input  wire [3:0]  load_sel,
    input  wire [11:0] load_data,
    // Read port.
    input  wire [3:0]  read_sel,
    output reg  [15:0] read_data
);

    reg [11:0] slot [0:`ANALOG_SLOT_COUNT-1];

    // One result slot per code up to 10; slot 4, at the keypad code in the middle, is never loaded or read.
    genvar s;
    generate
        for (s = 0; s < `ANALOG_SLOT_COUNT; s = s + 1) begin : g_slot
            // Slot number held at the select width so the compare below needs no padding.
            localparam [3:0] SLOT_ID = s;
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    slot[s] <= 12'h000;
                end else if (load && (load_sel == SLOT_ID) && (load_sel != `ANALOG_SLOT_KEYPAD)) begin
                    slot[s] <= load_data;
                end
            end
        end
    endgenerate

    // Right justified: the result MSB lands on bit 11 and the top nibble reads zero.
    always @* begin
        read_data = 16'h0000;
        if ((read_sel < `ANALOG_SLOT_COUNT) && (read_sel != `ANALOG_SLOT_KEYPAD)) begin
            read_data = {4'h0, slot[read_sel]};
        end
    end

endmodule

/* logic/result_register_readback.v */
// Result register bank: analog results, keypad scan results, DAC data and pull-up control.
//
// Summary of operation
// - Set upper pull-up bit turns pin open collector.
// - Power-up clears all result registers to zero.
// - DAC data register powers up nonzero default.
// - Analog results right justified, top nibble zero.
// - Writes to result registers are discarded.
// - Analog results read at fixed sequential codes.
// - Keypad raw, pending, status at three codes.
// - Each keypad bit is one matrix key.
// - Key bit index is 4*(column-1)+(row-1).
// - Raw and pending masked by column only.
// - Pending register keeps detections separately.
// - Status masked by key and column masks.
// - Column mask blocks pending and status updates.
`include "result_bank_regs.vh"

module result_register_readback (
    // Clock and reset.
    input  wire        clk_sys,
    input  wire        rst_n,

    // Command port from the serial framer.
    input  wire        cmd_valid,
    input  wire [15:0] cmd_word,
    input  wire [15:0] cmd_wr_data,

    // Read answer back to the serial framer.
    output reg         rd_valid,
    output reg  [15:0] rd_data,

    // Conversion results from the converter.
    input  wire        adc_done,
    input  wire [3:0]  adc_sel,
    input  wire [11:0] adc_result,

    // Keypad scan results from the scan engine.
    input  wire        scan_done,
    input  wire [15:0] scan_keys,

    // Current contents of the keypad mask registers.
    input  wire [15:0] key_mask_word,
    input  wire [15:0] column_mask_word,

    // Register driven outputs.
    output reg  [7:0]  weak_resistor_off_bits,
    output reg  [15:0] dac_data,
    output reg         pending_nonempty
);

    // Keypad result registers.
    reg  [15:0] key_scan_raw;
    reg  [15:0] key_pending_result;
    reg  [15:0] key_status_result;

    // Decoded command.
    wire        is_read;
    wire        is_write;
    reg  [15:0] next_rd_data;
    reg         read_of_pending;

    // Keypad gating terms.
    wire [3:0]  column_block;
    wire [15:0] column_key_block;
    wire [15:0] status_key_block;
    wire [15:0] raw_key_bit;
    wire [15:0] pending_key_bit;
    wire [15:0] status_key_bit;
    wire [15:0] analog_read_data;
    reg  [15:0] next_pending;

    // The top bit of a command word marks a read; everything else is a write.
    assign is_read  = cmd_valid & cmd_word[`CMD_READ_BIT];
    assign is_write = cmd_valid & ~cmd_word[`CMD_READ_BIT];

    // Column 4 block sits in the top bit of the column mask word.
    assign column_block = column_mask_word[`COLUMN_MASK_MSB:`COLUMN_MASK_LSB];

    // Turn the four column blocks into one block flag per key.
    column_block_expand u_column_block_expand (
        .column_block (column_block),
        .key_block    (column_key_block)
    );

    // Raw and pending see only the column mask; the per-key mask is left out on purpose.
    assign raw_key_bit     = scan_keys & ~column_key_block;
    assign pending_key_bit = scan_keys & ~column_key_block;

    // The status register also honours the per-key mask, bit for bit.
    assign status_key_block = column_key_block | key_mask_word;
    assign status_key_bit   = scan_keys & ~status_key_block;

    // Analog result store; its read port is indexed by the low nibble of the read code.
    analog_result_file u_analog_result_file (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .load      (adc_done),
        .load_sel  (adc_sel),
        .load_data (adc_result[`ANALOG_RESULT_MSB:0]),
        .read_sel  (cmd_word[3:0]),
        .read_data (analog_read_data)
    );

    // Raw scan register follows each completed scan, column masked keys reading zero.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            key_scan_raw <= `RESULT_RESET;
        end else if (scan_done) begin
            key_scan_raw <= raw_key_bit;
        end
    end

    // Status register: masked keys keep their old value instead of updating.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            key_status_result <= `RESULT_RESET;
        end else if (scan_done) begin
            key_status_result <= (key_status_result & status_key_block) | status_key_bit;
        end
    end

    // A read of the pending register hands its contents to the host and clears them.
    always @* begin
        read_of_pending = is_read && (cmd_word == `RD_KEY_PENDING);
    end

    // Pending bits are sticky; a detection in the same cycle as the clearing read wins.
    always @* begin
        next_pending = key_pending_result;
        if (read_of_pending) begin
            next_pending = 16'h0000;
        end
        if (scan_done) begin
            next_pending = next_pending | pending_key_bit;
        end
    end

    // Pending register, held apart from the raw and status registers.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            key_pending_result <= `RESULT_RESET;
        end else begin
            key_pending_result <= next_pending;
        end
    end

    // Summary flag so the interrupt logic elsewhere need not decode the word.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pending_nonempty <= 1'b0;
        end else begin
            pending_nonempty <= |next_pending;
        end
    end

    // Writable registers. Writes aimed at result codes match nothing here and are dropped.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dac_data <= `DAC_DATA_RESET;
        end else if (is_write && (cmd_word == `WR_DAC_DATA)) begin
            dac_data <= cmd_wr_data;
        end
    end

    // Pull-up control: only the upper byte is stored, the reserved byte is not kept.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            weak_resistor_off_bits <= 8'h00;
        end else if (is_write && (cmd_word == `WR_WEAK_RES_OFF)) begin
            weak_resistor_off_bits <= cmd_wr_data[`WEAK_RES_OFF_MSB:`WEAK_RES_OFF_LSB];
        end
    end

    // Read decode. An unknown read code answers zero rather than stalling the framer.
    always @* begin
        next_rd_data = 16'h0000;
        if (cmd_word == `RD_KEY_SCAN_RAW) begin
            next_rd_data = key_scan_raw;
        end else if (cmd_word == `RD_KEY_PENDING) begin
            next_rd_data = key_pending_result;
        end else if (cmd_word == `RD_KEY_STATUS) begin
            next_rd_data = key_status_result;
        end else if (cmd_word == `RD_DAC_DATA) begin
            next_rd_data = dac_data;
        end else if (cmd_word == `RD_WEAK_RES_OFF) begin
            next_rd_data = {weak_resistor_off_bits, 8'h00};
        end else if ((cmd_word >= `RD_HORIZ_POSITION) && (cmd_word <= `RD_THERMAL_TWO)) begin
            next_rd_data = analog_read_data;
        end
    end

    // Read answer is registered: it appears one cycle after the command is taken.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_data  <= 16'h0000;
        end else begin
            rd_valid <= is_read;
            if (is_read) begin
                rd_data <= next_rd_data;
            end
        end
    end

    // Writes to the analog and keypad codes reach no register; nothing else to do.

endmodule

/* tb/result_register_readback_assertions.sv */
// Port level checks of the result register bank.
`include "result_bank_regs.vh"
module result_register_readback_assertions (
    // Clock and reset.
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // Command port and answer.
    input wire logic        cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic [15:0] cmd_wr_data,
    input wire logic        rd_valid,
    input wire logic [15:0] rd_data,
    // Keypad side and register outputs.
    input wire logic        scan_done,
    input wire logic [15:0] scan_keys,
    input wire logic [15:0] column_mask_word,
    input wire logic [7:0]  weak_resistor_off_bits,
    input wire logic [15:0] dac_data,
    input wire logic        pending_nonempty
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // A column block bit covers all four keys of its column; the slice helper keeps $past on a plain signal.
    wire [15:0] blk   = {{4{column_mask_word[15]}}, {4{column_mask_word[14]}},
                         {4{column_mask_word[13]}}, {4{column_mask_word[12]}}};
    wire [7:0]  wr_hi = cmd_wr_data[15:8];
    sequence rd_take; cmd_valid && cmd_word[15]; endsequence
    sequence analog_take; cmd_valid && cmd_word[15:4] == 12'h800 && cmd_word[3:0] <= 4'ha && cmd_word[3:0] != 4'h4;
    endsequence
    sequence weak_take; cmd_valid && cmd_word == `WR_WEAK_RES_OFF; endsequence
    read_answer_a: assert property (rd_take |=> rd_valid)
        else $error("read command not answered");
    no_answer_a: assert property (!(cmd_valid && cmd_word[15]) |=> !rd_valid)
        else $error("answer without read");
    analog_nibble_a: assert property (analog_take |=> rd_data[15:12] == 4'h0)
        else $error("analog answer top nibble set");
    weak_write_a: assert property (weak_take |=> weak_resistor_off_bits == $past(wr_hi))
        else $error("pull-up bits not taken");
    weak_hold_a: assert property (!(cmd_valid && cmd_word == `WR_WEAK_RES_OFF) |=> $stable(weak_resistor_off_bits))
        else $error("pull-up bits changed");
    dac_hold_a: assert property (!(cmd_valid && cmd_word == `WR_DAC_DATA) |=> $stable(dac_data))
        else $error("dac data changed");
    data_hold_a: assert property (!rd_valid |-> $stable(rd_data))
        else $error("read data moved without answer");
    pend_set_a: assert property (scan_done && (scan_keys & ~blk) != 16'h0000 |=> pending_nonempty)
        else $error("pending flag not raised");
endmodule

bind result_register_readback result_register_readback_assertions u_result_register_readback_assertions (
    .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_wr_data(cmd_wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .scan_done(scan_done), .scan_keys(scan_keys),
    .column_mask_word(column_mask_word), .weak_resistor_off_bits(weak_resistor_off_bits),
    .dac_data(dac_data), .pending_nonempty(pending_nonempty));

/* tb/host_model.sv */
// Host side model issuing register commands and collecting read answers.
`include "result_bank_regs.vh"
module host_model (
    // Clock.
    input  wire logic        clk_sys,
    // Command port toward the bank.
    output logic             cmd_valid,
    output logic [15:0]      cmd_word,
    output logic [15:0]      cmd_wr_data,
    // Read answer from the bank.
    input  wire logic        rd_valid,
    input  wire logic [15:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle command port at time zero.
    initial begin
        cmd_valid   = 1'b0;
        cmd_word    = 16'h0000;
        cmd_wr_data = 16'h0000;
    end
    // One command, taken at the edge after it is raised; the answer is sampled mid-cycle once settled.
    task automatic xfer(input logic [15:0] code, input logic [15:0] wd, output logic [15:0] rd, output logic ok);
        @(posedge clk_sys);
        cmd_valid   <= 1'b1;
        cmd_word    <= code;
        cmd_wr_data <= (code == `WR_WEAK_RES_OFF) ? (wd & 16'hff00) : wd;
        @(posedge clk_sys);
        cmd_valid   <= 1'b0;
        cmd_wr_data <= ~wd; // Stale data is inverted so nothing can lean on it.
        @(negedge clk_sys);
        rd = rd_data;
        ok = (rd_valid === code[15]);
    endtask
endmodule

/* tb/result_register_readback_tb_top.sv */
// Self-checking bench of the result register bank.
`include "result_bank_regs.vh"
module result_register_readback_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0, rst_n = 1'b0, adc_done = 1'b0, scan_done = 1'b0;
    logic        cmd_valid, rd_valid, pending_nonempty, ok;
    logic [15:0] cmd_word, cmd_wr_data, rd_data, dac_data, rd;
    logic [15:0] scan_keys = 16'h0000, key_mask_word = 16'h0000, column_mask_word = 16'h0000;
    logic [3:0]  adc_sel = 4'h0;
    logic [11:0] adc_result = 12'h000;
    logic [7:0]  weak_resistor_off_bits;
    int          miscompares = 0;
    int          tests_run = 0;
    // Analog rows: read code beside the loaded value; the answer is that value right justified.
    logic [15:0] row_code [10] = '{`RD_HORIZ_POSITION, `RD_VERT_POSITION, `RD_PRESSURE_FIRST, `RD_PRESSURE_SECOND,
        `RD_BATTERY_ONE, `RD_BATTERY_TWO, `RD_AUXILIARY_ONE, `RD_AUXILIARY_TWO, `RD_THERMAL_ONE, `RD_THERMAL_TWO};
    logic [11:0] row_val [10] = '{12'hfff, 12'h800, 12'h001, 12'h5a5, 12'ha5a, 12'h123, 12'hedc, 12'h7ff,
        12'h0f0, 12'h3c3};

    // Clock and the two modules.
    always #2.5 clk_sys = ~clk_sys;
    host_model u_host_model (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
        .cmd_wr_data(cmd_wr_data), .rd_valid(rd_valid), .rd_data(rd_data));
    result_register_readback u_result_register_readback (.clk_sys(clk_sys), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_wr_data(cmd_wr_data), .rd_valid(rd_valid),
        .rd_data(rd_data), .adc_done(adc_done), .adc_sel(adc_sel), .adc_result(adc_result),
        .scan_done(scan_done), .scan_keys(scan_keys), .key_mask_word(key_mask_word),
        .column_mask_word(column_mask_word), .weak_resistor_off_bits(weak_resistor_off_bits),
        .dac_data(dac_data), .pending_nonempty(pending_nonempty));

    // Comparison, read and scan helpers.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [15:0] code, input logic [15:0] exp);
        u_host_model.xfer(code, 16'h0000, rd, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(rd, exp);
    endtask
    task automatic scan(input logic [15:0] k, input logic [15:0] km, input logic [15:0] cm);
        @(posedge clk_sys);
        scan_keys        <= k;
        key_mask_word    <= km;
        column_mask_word <= cm;
        scan_done        <= 1'b1;
        @(posedge clk_sys);
        scan_done        <= 1'b0;
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs well under a thousand cycles.
    initial begin
        #20000;
        miscompares++;
        tally_and_finish();
    end

    // Main sequence: all slots are loaded before any is read, so a mixed-up slot shows.
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys);
            adc_done   <= 1'b1;
            adc_sel    <= row_code[i][3:0];
            adc_result <= row_val[i];
            @(posedge clk_sys);
            adc_done   <= 1'b0;
        end
        for (int i = 0; i < 10; i++) begin
            rdchk(row_code[i], {4'h0, row_val[i]});
        end
        // Writes aimed at result codes leave them alone.
        u_host_model.xfer(16'h0000, 16'h0123, rd, ok);
        u_host_model.xfer(16'h0010, 16'hffff, rd, ok);
        rdchk(`RD_HORIZ_POSITION, {4'h0, row_val[0]});
        rdchk(`RD_KEY_PENDING, 16'h0000);
        u_host_model.xfer(`WR_WEAK_RES_OFF, 16'ha5ff, rd, ok);
        chk({8'h00, weak_resistor_off_bits}, 16'h00a5);
        rdchk(`RD_WEAK_RES_OFF, 16'ha500);
        u_host_model.xfer(`WR_DAC_DATA, 16'h00c3, rd, ok);
        chk(dac_data, 16'h00c3);
        // Column 4 blocked, keys of columns 1 and 2 masked per key.
        scan(16'hffff, 16'h00ff, 16'h8000);
        rdchk(`RD_KEY_SCAN_RAW, 16'h0fff);
        chk({15'h0000, pending_nonempty}, 16'h0001);
        rdchk(`RD_KEY_STATUS, 16'h0f00);
        rdchk(`RD_KEY_PENDING, 16'h0fff);
        rdchk(`RD_KEY_PENDING, 16'h0000);
        chk({15'h0000, pending_nonempty}, 16'h0000);
        // Every column blocked: status and pending keep their contents.
        scan(16'hffff, 16'h0000, 16'hf000);
        rdchk(`RD_KEY_STATUS, 16'h0f00);
        rdchk(`RD_KEY_PENDING, 16'h0000);
        // Only row 2, column 3 pressed.
        scan(16'h0200, 16'h0000, 16'h0000);
        rdchk(`RD_KEY_SCAN_RAW, 16'h0200);
        rdchk(`RD_KEY_STATUS, 16'h0200);
        // Second reset in mid-run clears every result, the DAC register returns to its default.
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk_sys);
        chk(dac_data, 16'h1000);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rdchk(row_code[i], 16'h0000);
        end
        rdchk(`RD_KEY_SCAN_RAW, 16'h0000);
        rdchk(`RD_KEY_PENDING, 16'h0000);
        rdchk(`RD_KEY_STATUS, 16'h0000);
        rdchk(`RD_DAC_DATA, 16'h1000);
        tally_and_finish();
    end
endmodule
